// ---- hw/pbd_bridge.sv ----
// Bridge end of the processor bus data tenure: decode, acknowledge, error and snoop broadcast.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Data bus: high half lanes 0-3, low 4-7.
// - Bridge drives data only when it sources.
// - Bridge acknowledges latched or valid data per beat.
// - External acknowledge ends beat, last ends tenure.
// - Claimed cycles: bridge never acknowledges itself.
// - Catastrophic error raises machine check output.
// - Bus errors and, when enabled, unsupported types raise error acknowledge.
// - Extended start draws error acknowledge when enabled.
// - Bridge starts transactions only for snoop broadcast.
// - Master asserts start with valid attributes.
// - Burst indicator driven by starter during burst.
// - Three-bit size ignored in, driven out.
// - Five-bit type decoded in, driven out.
// - Coherent, write-through, inhibit attributes travel both ways.
// - Active-low pins assert low.
module pbd_bridge #(
  parameter int DEPTH = pbd_pkg::FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst,
  pbd_bus_if.bridge bus,
  input wire logic i_err_enable,
  input wire logic i_fatal_error,
  input wire logic i_bus_error,
  input wire logic i_snoop_valid,
  output logic o_snoop_ready,
  input wire logic [pbd_pkg::ADDR_W-1:0] i_snoop_addr,
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output logic [pbd_pkg::DATA_W-1:0] o_wr_data,
  input wire logic [pbd_pkg::DATA_W-1:0] i_rd_data,
  output logic o_busy,
  output logic o_error_seen
);
  // One-hot states; the error state lasts one cycle and only carries the error pulse decision.
  // A stalled write beat simply stays in the data state until the buffer has room.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DATA = 4'b0010,
    ST_ERR = 4'b0100,
    ST_SNOOP = 4'b1000
  } pbd_state_e;

  // Tenure bookkeeping: the beat count steps per beat; burst flag, direction and claim are fixed at the start.
  pbd_state_e state;
  logic [pbd_pkg::BEATS_W-1:0] beat;
  logic burst;
  logic is_write;
  logic claimed;
  logic start_m;
  logic unsupported;
  logic beat_done;
  logic last_beat;
  logic own_ack;
  logic fifo_ready;
  logic fifo_push;
  logic [pbd_pkg::DATA_W-1:0] bus_data;

  // Pins are active low, so assertion is a low level.
  assign start_m = !bus.transfer_begin_n_m;
  // Lane 0 is the top byte of the high half, lane 7 the bottom byte of the low half.
  assign bus_data = {bus.data_high_half_m, bus.data_low_half_m};
  // Graphics read and write types count as unsupported; with errors off they still run as ordinary tenures.
  assign unsupported = (bus.transfer_type_field_m == pbd_pkg::TT_GFX_READ) ||
                       (bus.transfer_type_field_m == pbd_pkg::TT_GFX_WRITE);
  // A write beat is only acknowledged once the FIFO accepts it, so back-pressure stalls the beat.
  assign own_ack = (state == ST_DATA) && !claimed && (!is_write || fifo_ready);
  assign beat_done = own_ack || ((state == ST_DATA) && !bus.transfer_ack_n_ext);
  // A burst runs the full four beats unless a bus error ends it; a single beat ends at once.
  assign last_beat = !burst || (beat == pbd_pkg::BURST_LAST);
  // A beat that meets a bus error is not stored, since the master will not count it as done.
  assign fifo_push = (state == ST_DATA) && is_write && beat_done && !i_bus_error;
  // A snoop broadcast is only offered on an idle bus with no master start in the same cycle.
  assign o_snoop_ready = (state == ST_IDLE) && !start_m && (bus.extended_addr_begin_n);
  assign o_busy = (state != ST_IDLE);

  // Tenure sequencing: master starts take priority over a pending snoop broadcast.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      beat <= '0;
      burst <= 1'b0;
      is_write <= 1'b0;
      claimed <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          beat <= '0;
          if (!bus.extended_addr_begin_n) begin
            state <= i_err_enable ? ST_ERR : ST_DATA;
            burst <= 1'b0;
            // With errors off the access runs as an ordinary tenure, so its direction still matters.
            is_write <= (bus.transfer_type_field_m == pbd_pkg::TT_WRITE) ||
                        (bus.transfer_type_field_m == pbd_pkg::TT_GFX_WRITE);
            claimed <= 1'b0;
          end else if (start_m) begin
            state <= (unsupported && i_err_enable) ? ST_ERR : ST_DATA;
            burst <= !bus.burst_indicator_n_m;
            is_write <= (bus.transfer_type_field_m == pbd_pkg::TT_WRITE) ||
                        (bus.transfer_type_field_m == pbd_pkg::TT_GFX_WRITE);
            claimed <= !bus.local_slave_claim_n;
          end else if (i_snoop_valid) begin
            state <= ST_SNOOP;
          end
        end
        ST_DATA: begin
          if (i_bus_error) begin
            // The error pulse is already decided in this cycle; a pass through the error state would
            // repeat it, so the tenure ends here.
            state <= ST_IDLE;
          end else if (beat_done) begin
            beat <= beat + 1'b1;
            if (last_beat) begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ERR: begin
          // The pin process registers the error acknowledge in this cycle; it shows on the pin one cycle later.
          state <= ST_IDLE;
        end
        ST_SNOOP: begin
          // The start pulse is already registered; one cycle keeps it a single pulse.
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Pin drive: acknowledge, error and data come from flip-flops one cycle after decision.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bus.transfer_ack_n_b <= 1'b1;
      bus.transfer_error_ack_n <= 1'b1;
      bus.data_oe_b <= 1'b0;
      bus.data_high_half_b <= '0;
      bus.data_low_half_b <= '0;
    end else begin
      bus.transfer_ack_n_b <= !(own_ack && !i_bus_error);
      bus.transfer_error_ack_n <= !((state == ST_ERR) && i_err_enable) &&
                                  !((state == ST_DATA) && i_bus_error);
      // Drive the data lanes only for own read beats that are acknowledged; a beat lost to a bus
      // error leaves the lanes to whoever else may be driving them.
      bus.data_oe_b <= own_ack && !is_write && !i_bus_error;
      // Read data is sampled every cycle, so the memory side must hold it steady through the tenure.
      bus.data_high_half_b <= i_rd_data[pbd_pkg::DATA_W-1:pbd_pkg::HALF_W];
      bus.data_low_half_b <= i_rd_data[pbd_pkg::HALF_W-1:0];
    end
  end

  // Snoop broadcast: a one-cycle start with address and attributes valid.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bus.transfer_begin_n_b <= 1'b1;
      bus.transfer_begin_oe_b <= 1'b0;
      bus.addr_b <= '0;
      bus.burst_indicator_n_b <= 1'b1;
      bus.transfer_size_field_b <= '0;
      bus.transfer_type_field_b <= '0;
      bus.coherent_access_flag_n_b <= 1'b1;
      bus.write_through_flag_n_b <= 1'b1;
      bus.cache_inhibit_flag_n_b <= 1'b1;
    end else begin
      bus.transfer_begin_n_b <= !(o_snoop_ready && i_snoop_valid);
      bus.transfer_begin_oe_b <= o_snoop_ready && i_snoop_valid;
      if (o_snoop_ready && i_snoop_valid) begin
        bus.addr_b <= i_snoop_addr;
        bus.burst_indicator_n_b <= 1'b1;
        bus.transfer_size_field_b <= pbd_pkg::SIZE_DWORD;
        bus.transfer_type_field_b <= pbd_pkg::TT_SNOOP;
        bus.coherent_access_flag_n_b <= 1'b0;
        bus.write_through_flag_n_b <= 1'b1;
        bus.cache_inhibit_flag_n_b <= 1'b1;
      end
    end
  end

  // Machine check is sticky until reset, since the processor cannot recover anyway.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bus.machine_check_out_n <= 1'b1;
      o_error_seen <= 1'b0;
    end else begin
      if (i_fatal_error) begin
        bus.machine_check_out_n <= 1'b0;
      end
      // The error flag is a plain status level and, like the machine check, clears only on reset.
      if (state == ST_ERR || i_bus_error) begin
        o_error_seen <= 1'b1;
      end
    end
  end

  // Write data from the bus is sampled into the FIFO toward memory.
  pbd_fifo #(.WIDTH(pbd_pkg::DATA_W), .DEPTH(DEPTH)) u_wr_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(fifo_push),
    .o_in_ready(fifo_ready),
    .i_in_data(bus_data),
    .o_out_valid(o_wr_valid),
    .i_out_ready(i_wr_ready),
    .o_out_data(o_wr_data)
  );
endmodule : pbd_bridge
`default_nettype wire

// ---- inc/pbd_pkg.sv ----
// Shared constants for the processor bus data tenure bridge and its far end.
`default_nettype none
package pbd_pkg;
  localparam int DATA_W = 64;
  localparam int HALF_W = 32;
  localparam int LANE_W = 8;
  localparam int LANES = 8;
  localparam int SIZE_W = 3;
  localparam int TYPE_W = 5;
  localparam int ADDR_W = 32;
  localparam int BEATS_W = 2;
  // Index of the last beat in a burst transfer.
  localparam logic [BEATS_W-1:0] BURST_LAST = 2'h3;
  // Transfer type codes used by this block.
  localparam logic [TYPE_W-1:0] TT_READ = 5'h0A;
  localparam logic [TYPE_W-1:0] TT_WRITE = 5'h02;
  localparam logic [TYPE_W-1:0] TT_GFX_READ = 5'h16;
  localparam logic [TYPE_W-1:0] TT_GFX_WRITE = 5'h06;
  localparam logic [TYPE_W-1:0] TT_SNOOP = 5'h08;
  localparam logic [SIZE_W-1:0] SIZE_DWORD = 3'h0;
  localparam int FIFO_DEPTH = 16;
  localparam logic [LANE_W-1:0] RESET_BYTE = 8'h00;
endpackage : pbd_pkg
`default_nettype wire

// ---- inc/pbd_bus_if.sv ----
// Processor bus wires shared by the bridge and the bus master end; active-low pins carry _n.
`timescale 1ns/1ps
`default_nettype none
interface pbd_bus_if;
  logic transfer_begin_n_m;
  logic transfer_begin_n_b;
  logic transfer_begin_oe_b;
  logic extended_addr_begin_n;
  logic [pbd_pkg::ADDR_W-1:0] addr_m;
  logic [pbd_pkg::ADDR_W-1:0] addr_b;
  logic burst_indicator_n_m;
  logic burst_indicator_n_b;
  logic [pbd_pkg::SIZE_W-1:0] transfer_size_field_m;
  logic [pbd_pkg::SIZE_W-1:0] transfer_size_field_b;
  logic [pbd_pkg::TYPE_W-1:0] transfer_type_field_m;
  logic [pbd_pkg::TYPE_W-1:0] transfer_type_field_b;
  logic coherent_access_flag_n_m;
  logic coherent_access_flag_n_b;
  logic write_through_flag_n_m;
  logic write_through_flag_n_b;
  logic cache_inhibit_flag_n_m;
  logic cache_inhibit_flag_n_b;
  logic [pbd_pkg::HALF_W-1:0] data_high_half_m;
  logic [pbd_pkg::HALF_W-1:0] data_low_half_m;
  logic data_oe_m;
  logic [pbd_pkg::HALF_W-1:0] data_high_half_b;
  logic [pbd_pkg::HALF_W-1:0] data_low_half_b;
  logic data_oe_b;
  logic transfer_ack_n_b;
  logic transfer_ack_n_ext;
  logic local_slave_claim_n;
  logic transfer_error_ack_n;
  logic machine_check_out_n;
  modport bridge (
    input transfer_begin_n_m, extended_addr_begin_n, addr_m, burst_indicator_n_m,
    input transfer_size_field_m, transfer_type_field_m, coherent_access_flag_n_m,
    input write_through_flag_n_m, cache_inhibit_flag_n_m, data_high_half_m, data_low_half_m,
    input data_oe_m, transfer_ack_n_ext, local_slave_claim_n,
    output transfer_begin_n_b, transfer_begin_oe_b, addr_b, burst_indicator_n_b,
    output transfer_size_field_b, transfer_type_field_b, coherent_access_flag_n_b,
    output write_through_flag_n_b, cache_inhibit_flag_n_b, data_high_half_b, data_low_half_b,
    output data_oe_b, transfer_ack_n_b, transfer_error_ack_n, machine_check_out_n
  );
  modport master (
    output transfer_begin_n_m, extended_addr_begin_n, addr_m, burst_indicator_n_m,
    output transfer_size_field_m, transfer_type_field_m, coherent_access_flag_n_m,
    output write_through_flag_n_m, cache_inhibit_flag_n_m, data_high_half_m, data_low_half_m,
    output data_oe_m, transfer_ack_n_ext, local_slave_claim_n,
    input transfer_begin_n_b, transfer_begin_oe_b, addr_b, burst_indicator_n_b,
    input transfer_size_field_b, transfer_type_field_b, coherent_access_flag_n_b,
    input write_through_flag_n_b, cache_inhibit_flag_n_b, data_high_half_b, data_low_half_b,
    input data_oe_b, transfer_ack_n_b, transfer_error_ack_n, machine_check_out_n
  );
endinterface : pbd_bus_if
`default_nettype wire

// ---- hw/pbd_fifo.sv ----
// Parameterised FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module pbd_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Full and empty follow the count so that back-pressure is honest.
  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_ptr];

  // Storage is written without reset; only valid entries are ever read out.
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // Pointers wrap at the depth, which must be a power of two.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : pbd_fifo
`default_nettype wire

// ---- hw/pbd_master.sv ----
// Far end: a bus master with an optional local slave that can claim and acknowledge.
`timescale 1ns/1ps
`default_nettype none
module pbd_master (
  input wire logic i_clk,
  input wire logic i_rst,
  pbd_bus_if.master bus,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic [pbd_pkg::ADDR_W-1:0] i_req_addr,
  input wire logic [pbd_pkg::TYPE_W-1:0] i_req_type,
  input wire logic [pbd_pkg::SIZE_W-1:0] i_req_size,
  input wire logic i_req_burst,
  input wire logic i_req_direct,
  input wire logic i_req_claim,
  input wire logic [pbd_pkg::DATA_W-1:0] i_req_data,
  input wire logic [2:0] i_req_attr,
  output logic o_done,
  output logic o_error,
  output logic [pbd_pkg::DATA_W-1:0] o_rd_data,
  output logic o_snoop_seen,
  output logic [pbd_pkg::ADDR_W-1:0] o_snoop_addr
);
  logic active;
  logic claim;
  logic burst;
  logic [pbd_pkg::BEATS_W-1:0] beat;
  logic ack;

  assign o_req_ready = !active;
  // Acknowledge seen from the bridge, or from our own slave on a claimed cycle.
  assign ack = active && (claim ? 1'b1 : !bus.transfer_ack_n_b);

  // Start and attributes go out together for one cycle.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bus.transfer_begin_n_m <= 1'b1;
      bus.extended_addr_begin_n <= 1'b1;
      bus.addr_m <= '0;
      bus.transfer_type_field_m <= '0;
      bus.transfer_size_field_m <= '0;
      bus.coherent_access_flag_n_m <= 1'b1;
      bus.write_through_flag_n_m <= 1'b1;
      bus.cache_inhibit_flag_n_m <= 1'b1;
      bus.local_slave_claim_n <= 1'b1;
    end else begin
      bus.transfer_begin_n_m <= !(i_req_valid && !active && !i_req_direct);
      bus.extended_addr_begin_n <= !(i_req_valid && !active && i_req_direct);
      bus.local_slave_claim_n <= !(i_req_valid && !active && i_req_claim);
      if (i_req_valid && !active) begin
        bus.addr_m <= i_req_addr;
        bus.transfer_type_field_m <= i_req_type;
        bus.transfer_size_field_m <= i_req_size;
        {bus.coherent_access_flag_n_m, bus.write_through_flag_n_m,
         bus.cache_inhibit_flag_n_m} <= ~i_req_attr;
      end
    end
  end

  // Tenure tracking, burst indicator and local slave acknowledge.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      active <= 1'b0;
      claim <= 1'b0;
      burst <= 1'b0;
      beat <= '0;
      bus.burst_indicator_n_m <= 1'b1;
      bus.transfer_ack_n_ext <= 1'b1;
      bus.data_oe_m <= 1'b0;
      bus.data_high_half_m <= '0;
      bus.data_low_half_m <= '0;
      o_done <= 1'b0;
      o_error <= 1'b0;
      o_rd_data <= '0;
    end else begin
      o_done <= 1'b0;
      o_error <= 1'b0;
      bus.transfer_ack_n_ext <= !(active && claim);
      if (i_req_valid && !active) begin
        active <= 1'b1;
        claim <= i_req_claim && !i_req_direct;
        burst <= i_req_burst && !i_req_direct;
        beat <= '0;
        bus.burst_indicator_n_m <= !(i_req_burst && !i_req_direct);
        // Only a write puts data on the lanes; a read leaves them to the bridge.
        bus.data_oe_m <= (i_req_type == pbd_pkg::TT_WRITE) || (i_req_type == pbd_pkg::TT_GFX_WRITE);
        bus.data_high_half_m <= i_req_data[pbd_pkg::DATA_W-1:pbd_pkg::HALF_W];
        bus.data_low_half_m <= i_req_data[pbd_pkg::HALF_W-1:0];
      end else if (active && !bus.transfer_error_ack_n) begin
        active <= 1'b0;
        o_error <= 1'b1;
        bus.burst_indicator_n_m <= 1'b1;
        bus.data_oe_m <= 1'b0;
      end else if (ack) begin
        beat <= beat + 1'b1;
        if (!bus.transfer_ack_n_b) begin
          o_rd_data <= {bus.data_high_half_b, bus.data_low_half_b};
        end
        if (!burst || beat == pbd_pkg::BURST_LAST) begin
          active <= 1'b0;
          o_done <= 1'b1;
          bus.burst_indicator_n_m <= 1'b1;
          bus.data_oe_m <= 1'b0;
        end
      end
    end
  end

  // Snoop broadcasts from the bridge are reported upward.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_snoop_seen <= 1'b0;
      o_snoop_addr <= '0;
    end else begin
      o_snoop_seen <= !bus.transfer_begin_n_b;
      if (!bus.transfer_begin_n_b) begin
        o_snoop_addr <= bus.addr_b;
      end
    end
  end
endmodule : pbd_master
`default_nettype wire

// ---- verification/pbd_chk.sv ----
// Concurrent checks on the processor bus wires between the bridge and the bus master end.
`timescale 1ns/1ps
`default_nettype none
module pbd_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic transfer_begin_n_m,
  input wire logic extended_addr_begin_n,
  input wire logic burst_indicator_n_m,
  input wire logic [pbd_pkg::TYPE_W-1:0] transfer_type_field_m,
  input wire logic local_slave_claim_n,
  input wire logic data_oe_m,
  input wire logic transfer_begin_n_b,
  input wire logic transfer_begin_oe_b,
  input wire logic [pbd_pkg::SIZE_W-1:0] transfer_size_field_b,
  input wire logic [pbd_pkg::TYPE_W-1:0] transfer_type_field_b,
  input wire logic coherent_access_flag_n_b,
  input wire logic data_oe_b,
  input wire logic transfer_ack_n_b,
  input wire logic transfer_error_ack_n,
  input wire logic machine_check_out_n
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // A plain single read that the bridge must answer itself; a bus error may end it instead.
  sequence s_read_start;
    !transfer_begin_n_m && extended_addr_begin_n && burst_indicator_n_m && local_slave_claim_n &&
      transfer_type_field_m == pbd_pkg::TT_READ;
  endsequence
  sequence s_read_answer;
    (!transfer_ack_n_b && data_oe_b) || !transfer_error_ack_n;
  endsequence
  sequence s_claim_start;
    !transfer_begin_n_m && !local_slave_claim_n;
  endsequence

  a_read_gets_ack: assert property (s_read_start |-> ##[1:6] s_read_answer)
    else $error("bridge read was not acknowledged in time");
  a_claim_no_ack: assert property (s_claim_start |-> transfer_ack_n_b [*4])
    else $error("bridge acknowledged a claimed tenure");
  a_no_data_fight: assert property (!(data_oe_b && data_oe_m))
    else $error("both ends drive the data bus");
  a_snoop_attrs_ok: assert property (
    !transfer_begin_n_b |-> transfer_begin_oe_b && !coherent_access_flag_n_b &&
    transfer_type_field_b == pbd_pkg::TT_SNOOP && transfer_size_field_b == pbd_pkg::SIZE_DWORD)
    else $error("snoop start carries wrong attributes");
  a_snoop_one_cycle: assert property (!transfer_begin_n_b |=> transfer_begin_n_b)
    else $error("snoop start longer than one cycle");
  a_start_one_cycle: assert property (!transfer_begin_n_m |=> transfer_begin_n_m)
    else $error("master start longer than one cycle");
  a_burst_held_on: assert property (!transfer_begin_n_m && !burst_indicator_n_m |=> !burst_indicator_n_m)
    else $error("burst indicator dropped after start");
  a_error_one_pulse: assert property ($fell(transfer_error_ack_n) |=> transfer_error_ack_n)
    else $error("error acknowledge longer than one cycle");
  a_mcheck_stays: assert property (!machine_check_out_n |=> !machine_check_out_n)
    else $error("machine check released without reset");
endmodule : pbd_chk
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench joining the bridge and the bus master end across the processor bus.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic err; logic chk; logic [63:0] rd;} pbd_note_s;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic err_en = 1'b1, fatal = 1'b0, bus_err = 1'b0, snp_valid = 1'b0, wr_ready = 1'b1;
  logic req_valid = 1'b0, req_burst = 1'b0, req_direct = 1'b0, req_claim = 1'b0;
  logic [31:0] snp_addr = 32'h0, req_addr = 32'h0, snp_out;
  logic [4:0] req_type = 5'h0;
  logic [2:0] req_size = 3'h0, req_attr = 3'h0;
  logic [63:0] rd_data = 64'h0, req_data = 64'h0, wr_data, rd_out;
  logic snp_ready, wr_valid, busy, err_seen, req_ready, done, err, snp_seen;
  int errors = 0, n_compared = 0;
  integer seed = 32'hBDCB56AD;
  pbd_note_s qd[$];
  pbd_note_s n;
  logic [63:0] qw[$];
  logic [31:0] qs[$];

  // Free-running bus clock at 40 MHz.
  always #12.5 i_clk = ~i_clk;

  pbd_bus_if bus ();
  pbd_bridge #(.DEPTH(16)) u_pbd_bridge (.i_clk(i_clk), .i_rst(i_rst), .bus(bus), .i_err_enable(err_en),
    .i_fatal_error(fatal), .i_bus_error(bus_err), .i_snoop_valid(snp_valid), .o_snoop_ready(snp_ready),
    .i_snoop_addr(snp_addr), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr_data(wr_data),
    .i_rd_data(rd_data), .o_busy(busy), .o_error_seen(err_seen));
  pbd_master u_pbd_master (.i_clk(i_clk), .i_rst(i_rst), .bus(bus), .i_req_valid(req_valid),
    .o_req_ready(req_ready), .i_req_addr(req_addr), .i_req_type(req_type), .i_req_size(req_size),
    .i_req_burst(req_burst), .i_req_direct(req_direct), .i_req_claim(req_claim), .i_req_data(req_data),
    .i_req_attr(req_attr), .o_done(done), .o_error(err), .o_rd_data(rd_out), .o_snoop_seen(snp_seen),
    .o_snoop_addr(snp_out));
  pbd_chk u_pbd_chk (.i_clk(i_clk), .i_rst(i_rst), .transfer_begin_n_m(bus.transfer_begin_n_m),
    .extended_addr_begin_n(bus.extended_addr_begin_n), .burst_indicator_n_m(bus.burst_indicator_n_m),
    .transfer_type_field_m(bus.transfer_type_field_m), .local_slave_claim_n(bus.local_slave_claim_n),
    .data_oe_m(bus.data_oe_m), .transfer_begin_n_b(bus.transfer_begin_n_b),
    .transfer_begin_oe_b(bus.transfer_begin_oe_b), .transfer_size_field_b(bus.transfer_size_field_b),
    .transfer_type_field_b(bus.transfer_type_field_b), .coherent_access_flag_n_b(bus.coherent_access_flag_n_b),
    .data_oe_b(bus.data_oe_b), .transfer_ack_n_b(bus.transfer_ack_n_b),
    .transfer_error_ack_n(bus.transfer_error_ack_n), .machine_check_out_n(bus.machine_check_out_n));

  // Comparison helpers; case inequality keeps an unknown from passing.
  task automatic cmp_bit(input string what, input logic e, input logic s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("FAIL %s expected %b seen %b", what, e, s);
    end
  endtask : cmp_bit
  task automatic cmp_word(input string what, input logic [63:0] e, input logic [63:0] s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, e, s);
    end
  endtask : cmp_word
  task automatic tick;
    @(posedge i_clk);
    #1;
  endtask : tick
  task automatic idle;
    tick();
    while (req_ready !== 1'b1) tick();
  endtask : idle

  // One master request; read data is held on the bridge side until the tenure ends.
  task automatic req(input logic [4:0] t, input logic b, input logic d, input logic c, input logic e);
    pbd_note_s m;
    idle();
    req_type = t;
    req_burst = b;
    req_direct = d;
    req_claim = c;
    req_data = {$random(seed), $random(seed)};
    req_addr = $random(seed) & 32'hFFFFFFF8;
    req_attr = 3'($random(seed));
    rd_data = req_data;
    m.err = e;
    m.chk = (t == pbd_pkg::TT_READ) && !c && !e;
    m.rd = req_data;
    qd.push_back(m);
    if (!e && (t == pbd_pkg::TT_WRITE || t == pbd_pkg::TT_GFX_WRITE)) qw.push_back(req_data);
    req_valid = 1'b1;
    tick();
    req_valid = 1'b0;
  endtask : req

  task automatic tally_and_finish;
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // Watcher: each result that appears takes the oldest note of its kind.
  always @(negedge i_clk) begin
    if (!i_rst) begin
      if (done || err) begin
        n = qd.pop_front();
        cmp_bit("error", n.err, err);
        if (n.chk) cmp_word("rd_data", n.rd, rd_out);
      end
      if (wr_valid && wr_ready) cmp_word("wr_data", qw.pop_front(), wr_data);
      if (snp_seen) cmp_word("snoop_addr", {32'h0, qs.pop_front()}, {32'h0, snp_out});
      if (!bus.transfer_begin_n_m) cmp_word("start",
        {24'h0, req_addr, req_type, ~req_attr}, {24'h0, bus.addr_m, bus.transfer_type_field_m,
        bus.coherent_access_flag_n_m, bus.write_through_flag_n_m, bus.cache_inhibit_flag_n_m});
      if (!bus.transfer_ack_n_b && bus.data_oe_b) cmp_word("lanes", rd_data,
        {bus.data_high_half_b, bus.data_low_half_b});
    end
  end

  // Main sequence: plain, burst, claimed, error, snoop, full buffer and machine check.
  initial begin
    repeat (5) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      req(pbd_pkg::TT_READ, i[0], 1'b0, 1'b0, 1'b0);
      req(pbd_pkg::TT_WRITE, 1'b0, 1'b0, 1'b0, 1'b0);
    end
    req(pbd_pkg::TT_READ, 1'b0, 1'b0, 1'b1, 1'b0);
    req(pbd_pkg::TT_READ, 1'b1, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      idle();
      err_en = i[0];
      req(i[2] ? (i[1] ? pbd_pkg::TT_WRITE : pbd_pkg::TT_READ) :
        (i[1] ? pbd_pkg::TT_GFX_WRITE : pbd_pkg::TT_GFX_READ), 1'b0, i[2], 1'b0, i[0]);
    end
    idle();
    bus_err = 1'b1;
    req(pbd_pkg::TT_READ, 1'b0, 1'b0, 1'b0, 1'b1);
    idle();
    bus_err = 1'b0;
    for (int i = 0; i < 3; i++) begin
      snp_addr = $random(seed);
      qs.push_back(snp_addr);
      snp_valid = 1'b1;
      while (snp_ready !== 1'b1) tick();
      tick();
      snp_valid = 1'b0;
      tick();
    end
    // The seventeenth write must wait for room in the sixteen-word buffer.
    wr_ready = 1'b0;
    for (int i = 0; i < 17; i++) req(pbd_pkg::TT_WRITE, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (20) tick();
    cmp_word("pending", 64'd1, 64'(qd.size()));
    cmp_bit("refused", 1'b0, req_ready);
    cmp_bit("busy_stalled", 1'b1, busy);
    while (qw.size() > 0) begin
      wr_ready = 1'($random(seed));
      tick();
    end
    wr_ready = 1'b1;
    idle();
    cmp_bit("drained", 1'b0, wr_valid);
    cmp_bit("busy_idle", 1'b0, busy);
    cmp_bit("err_seen", 1'b1, err_seen);
    cmp_bit("mcheck_quiet", 1'b1, bus.machine_check_out_n);
    fatal = 1'b1;
    repeat (3) tick();
    fatal = 1'b0;
    repeat (3) tick();
    cmp_bit("mcheck", 1'b0, bus.machine_check_out_n);
    tally_and_finish();
  end

  // Watchdog at 10000 cycles, well beyond the few hundred cycles the sequence needs.
  initial begin
    #250000;
    errors++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
